// File: hdl/gcr_pkg.sv
// package for the global chip-control register group
// Operation
// - read-only id word, boundary-scan field layout
// - 32-bit scratch word, resets zero, stored
// - writing one to bit 0 resets chip
// - reset request bit clears through its reset
// - protected processor subsystem skips soft reset
// - memory-failure bit set on startup failure
// - sibling groups sit at fixed offsets
package gcr_pkg;
   // register byte offsets
   localparam logic [8:0] OFS_CHIP_IDENTIFICATION = 9'h000;
   localparam logic [8:0] OFS_SCRATCH = 9'h004;
   localparam logic [8:0] OFS_RST_CTRL = 9'h008;
   localparam logic [8:0] OFS_HARDWARE_STATUS = 9'h010;
   localparam logic [8:0] OFS_IRQ_STAT = 9'h014;
   localparam logic [8:0] OFS_IRQ_MASK = 9'h018;
   // sibling group offsets
   localparam logic [8:0] OFS_PROC_ACCESS_GRP = 9'h020;
   localparam logic [8:0] OFS_MDIO_MASTER_GRP = 9'h05c;
   localparam logic [8:0] MDIO_MASTER_SPACING = 9'h024;
   localparam int MDIO_MASTER_COUNT = 2;
   localparam logic [8:0] OFS_MDIO_SCAN_GRP = 9'h0a4;
   // id field positions
   localparam int REV_LSB = 28;
   localparam int PART_LSB = 12;
   localparam int MAKER_LSB = 1;
   // bit positions
   localparam int SOFT_RST_BIT = 0;
   localparam int MEM_FAIL_BIT = 0;
   localparam int IRQ_MEM_FAIL = 0;
   localparam int IRQ_SOFT_RST = 1;
   localparam int IRQ_W = 2;
   // reset values
   localparam logic [31:0] SCRATCH_RST = 32'h0000_0000;
   localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
   // soft reset pulse length, cycles
   localparam logic [3:0] SOFT_RST_CYCLES = 4'h8;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum {ST_IDLE, ST_RESET} gcr_rst_e;

   typedef struct packed {
      logic [31:0] scratch_q;
      logic soft_rst_req_q;
      logic [3:0] rst_cnt_q;
      logic mem_fail_q;
      logic [IRQ_W-1:0] irq_stat_q;
      logic [IRQ_W-1:0] irq_mask_q;
      logic irq_q;
      logic chip_rst_q;
      logic proc_rst_q;
      logic aw_seen_q;
      logic [8:0] aw_addr_q;
      logic w_seen_q;
      logic [31:0] w_data_q;
      logic [3:0] w_strb_q;
      logic bvalid_q;
      logic [1:0] bresp_q;
      logic rvalid_q;
      logic [31:0] rdata_q;
      logic [1:0] rresp_q;
      logic [1:0] mf_sync_q;
      logic [1:0] prot_sync_q;
      logic awready_q;
      logic wready_q;
      logic arready_q;
      gcr_rst_e seq_q;
   } gcr_state_s;
endpackage

// File: hdl/gcr_chip_regs.sv
// global chip-control register group with axi4-lite slave
`timescale 1ns/1ps
module gcr_chip_regs
   import gcr_pkg::*;
#(
   parameter logic [3:0] REVISION_CODE = 4'h3,   // arbitrary value
   parameter logic [15:0] PART_CODE = 16'h1234,  // arbitrary value
   parameter logic [10:0] MAKER_CODE = 11'h155   // arbitrary value
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [8:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [8:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // chip status and reset
   input wire logic mem_init_fail,
   input wire logic proc_rst_protect,
   output logic chip_soft_rst,
   output logic proc_soft_rst,
   output logic irq
);

   // registered state of the whole group, current and next
   gcr_state_s s_q;
   gcr_state_s s_d;

   // identification word, fixed by the code parameters
   logic [31:0] id_word;

   // byte lane merge for partial scratch writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // word-aligned form of a bus address, low two bits dropped
   function automatic logic [8:0] align(input logic [8:0] a);
      return {a[8:2], 2'b00};
   endfunction

   // address decode, used by read and write
   function automatic logic mapped(input logic [8:0] a);
      return (a == OFS_CHIP_IDENTIFICATION) || (a == OFS_SCRATCH) || (a == OFS_RST_CTRL) ||
             (a == OFS_HARDWARE_STATUS) || (a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK);
   endfunction

   // offsets that belong to the sibling groups of the block
   function automatic logic sibling(input logic [8:0] a);
      return (a >= OFS_PROC_ACCESS_GRP);
   endfunction

   // bus response for one access, used by read and write
   function automatic logic [1:0] resp_for(input logic [8:0] a);
      logic ok;
      ok = mapped(a) && !sibling(a);
      return ok ? RESP_OKAY : RESP_SLVERR;
   endfunction

   // read data mux, unmapped offsets read zero
   function automatic logic [31:0] read_word(input logic [8:0] a, input gcr_state_s s,
                                             input logic [31:0] id);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (a)
         OFS_CHIP_IDENTIFICATION: begin
            r = id;
         end
         OFS_SCRATCH: begin
            r = s.scratch_q;
         end
         OFS_RST_CTRL: begin
            r[SOFT_RST_BIT] = s.soft_rst_req_q;
         end
         OFS_HARDWARE_STATUS: begin
            r[MEM_FAIL_BIT] = s.mem_fail_q;
         end
         OFS_IRQ_STAT: begin
            r[IRQ_W-1:0] = s.irq_stat_q;
         end
         OFS_IRQ_MASK: begin
            r[IRQ_W-1:0] = s.irq_mask_q;
         end
         default: begin
            r = 32'h0000_0000;
         end
      endcase
      return r;
   endfunction

   // revision, part and maker codes with the fixed one at bit 0
   assign id_word = {REVISION_CODE, PART_CODE, MAKER_CODE, 1'b1};

   // next state of every register in the group
   always_comb begin
      logic [8:0] wa;
      logic [31:0] wd;
      logic [3:0] ws;
      logic aw_take;
      logic w_take;
      logic ar_take;
      logic do_wr;
      logic [IRQ_W-1:0] ev;
      logic [8:0] ra;
      s_d = s_q;
      ev = '0;
      // handshakes seen at this edge
      aw_take = s_axi_awvalid && s_q.awready_q;
      w_take = s_axi_wvalid && s_q.wready_q;
      ar_take = s_axi_arvalid && s_q.arready_q;
      // held or live write fields
      wa = s_q.aw_seen_q ? s_q.aw_addr_q : align(s_axi_awaddr);
      wd = s_q.w_seen_q ? s_q.w_data_q : s_axi_wdata;
      ws = s_q.w_seen_q ? s_q.w_strb_q : s_axi_wstrb;
      ra = align(s_axi_araddr);
      do_wr = (s_q.aw_seen_q || aw_take) && (s_q.w_seen_q || w_take) && !s_q.bvalid_q;

      // input synchronisers, only the second stage is read
      s_d.mf_sync_q = {s_q.mf_sync_q[0], mem_init_fail};
      s_d.prot_sync_q = {s_q.prot_sync_q[0], proc_rst_protect};

      // sticky failure flag, only hardware sets it
      if (s_q.mf_sync_q[1] && !s_q.mem_fail_q) begin
         s_d.mem_fail_q = 1'b1;
         ev[IRQ_MEM_FAIL] = 1'b1;
      end

      // capture an address that arrives ahead of its data
      if (aw_take) begin
         s_d.aw_seen_q = 1'b1;
         s_d.aw_addr_q = align(s_axi_awaddr);
      end

      // capture data that arrives ahead of its address
      if (w_take) begin
         s_d.w_seen_q = 1'b1;
         s_d.w_data_q = s_axi_wdata;
         s_d.w_strb_q = s_axi_wstrb;
      end

      // write commit once both halves are in
      if (do_wr) begin
         s_d.aw_seen_q = 1'b0;
         s_d.w_seen_q = 1'b0;
         s_d.bvalid_q = 1'b1;
         s_d.bresp_q = resp_for(wa);
         case (wa)
            OFS_SCRATCH: begin
               s_d.scratch_q = merge(s_q.scratch_q, wd, ws);
            end
            OFS_RST_CTRL: begin
               if (ws[0] && wd[SOFT_RST_BIT]) begin
                  s_d.soft_rst_req_q = 1'b1;
               end
            end
            OFS_IRQ_MASK: begin
               if (ws[0]) begin
                  s_d.irq_mask_q = wd[IRQ_W-1:0];
               end
            end
            OFS_IRQ_STAT: begin
               if (ws[0]) begin
                  s_d.irq_stat_q = s_q.irq_stat_q & ~wd[IRQ_W-1:0];
               end
            end
            default: begin
               // id and hardware status keep their value
               s_d.scratch_q = s_d.scratch_q;
            end
         endcase
      end

      // write answer stands until the master takes it
      if (s_q.bvalid_q && s_axi_bready) begin
         s_d.bvalid_q = 1'b0;
      end

      // read answer, one cycle after the address is taken
      if (ar_take) begin
         s_d.rvalid_q = 1'b1;
         s_d.rdata_q = read_word(ra, s_q, id_word);
         s_d.rresp_q = resp_for(ra);
      end else if (s_q.rvalid_q && s_axi_rready) begin
         s_d.rvalid_q = 1'b0;
      end

      // soft reset sequencer, fixed-length pulse then self clear
      case (s_q.seq_q)
         ST_IDLE: begin
            if (s_q.soft_rst_req_q) begin
               s_d.seq_q = ST_RESET;
               s_d.rst_cnt_q = SOFT_RST_CYCLES;
               s_d.chip_rst_q = 1'b1;
               s_d.proc_rst_q = !s_q.prot_sync_q[1];
               ev[IRQ_SOFT_RST] = 1'b1;
            end
         end
         ST_RESET: begin
            s_d.rst_cnt_q = s_q.rst_cnt_q - 4'h1;
            if (s_q.rst_cnt_q == 4'h1) begin
               s_d.seq_q = ST_IDLE;
               s_d.chip_rst_q = 1'b0;
               s_d.proc_rst_q = 1'b0;
               s_d.soft_rst_req_q = 1'b0;
               s_d.scratch_q = SCRATCH_RST;
            end
         end
         default: begin
            s_d.seq_q = ST_IDLE;
         end
      endcase

      // event set wins over a clear in the same cycle
      s_d.irq_stat_q = s_d.irq_stat_q | ev;
      s_d.irq_q = |(s_d.irq_stat_q & s_d.irq_mask_q);

      // ready flags registered from the next state
      s_d.awready_q = !s_d.aw_seen_q && !s_d.bvalid_q;
      s_d.wready_q = !s_d.w_seen_q && !s_d.bvalid_q;
      s_d.arready_q = !s_d.rvalid_q;
   end

   // state register, readies stay low until the first edge after release
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
         s_q.scratch_q <= SCRATCH_RST;
         s_q.irq_stat_q <= IRQ_RST;
         s_q.irq_mask_q <= IRQ_RST;
         s_q.seq_q <= ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs from flip-flops
   assign s_axi_awready = s_q.awready_q;
   assign s_axi_wready = s_q.wready_q;
   assign s_axi_arready = s_q.arready_q;
   assign s_axi_bvalid = s_q.bvalid_q;
   assign s_axi_bresp = s_q.bresp_q;
   assign s_axi_rvalid = s_q.rvalid_q;
   assign s_axi_rdata = s_q.rdata_q;
   assign s_axi_rresp = s_q.rresp_q;
   assign chip_soft_rst = s_q.chip_rst_q;
   assign proc_soft_rst = s_q.proc_rst_q;
   assign irq = s_q.irq_q;
endmodule

// File: verification/gcr_chip_regs_props.sv
// assertion checker for the chip-control register group
`timescale 1ns/1ps
module gcr_chip_regs_props (
   // clock and reset
   input logic aclk, aresetn,
   // register bus
   input logic [8:0] s_axi_awaddr,
   input logic [31:0] s_axi_wdata, s_axi_rdata,
   input logic [1:0] s_axi_bresp,
   input logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
   input logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
   input logic s_axi_rvalid, s_axi_rready,
   // soft reset
   input logic proc_rst_protect, chip_soft_rst, proc_soft_rst
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // write taken on both channels together
   sequence s_wr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // eight cycles of soft reset, then low
   sequence s_pulse;
      chip_soft_rst [*8] ##1 !chip_soft_rst;
   endsequence
   property p_pulse; $rose(chip_soft_rst) |-> s_pulse; endproperty
   property p_req; s_wr ##0 (s_axi_awaddr == 9'h008 && s_axi_wdata[0]) |-> ##[1:3] chip_soft_rst;
   endproperty
   property p_prot; proc_rst_protect [*5] ##1 $rose(chip_soft_rst) |-> !proc_soft_rst [*8];
   endproperty
   property p_follow; $rose(proc_soft_rst) |-> $rose(chip_soft_rst); endproperty
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   property p_wlat; s_wr |=> s_axi_bvalid; endproperty
   property p_release; $rose(aresetn) |=> s_axi_awready && s_axi_arready && !chip_soft_rst;
   endproperty
   a_pulse: assert property (p_pulse) else $error("reset pulse length");
   a_req: assert property (p_req) else $error("reset request ignored");
   a_prot: assert property (p_prot) else $error("protected core reset");
   a_follow: assert property (p_follow) else $error("core reset alone");
   a_bhold: assert property (p_bhold) else $error("write answer dropped");
   a_rhold: assert property (p_rhold) else $error("read answer dropped");
   a_rlat: assert property (p_rlat) else $error("read answer late");
   a_wlat: assert property (p_wlat) else $error("write answer late");
   a_release: assert property (p_release) else $error("bad state after reset");
endmodule
bind gcr_chip_regs gcr_chip_regs_props u_gcr_chip_regs_props (.*);

// File: verification/tb.sv
// self-checking bench for the chip-control register group
`timescale 1ns/1ps
module tb;
   import gcr_pkg::*;
   localparam logic [31:0] ID = {4'h3, 16'h1234, 11'h155, 1'b1};
   logic aclk = 0, aresetn = 0, mem_init_fail = 0, proc_rst_protect = 0;
   logic [31:0] pcnt = 0, ccnt = 0;
   logic [8:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, chip_soft_rst, proc_soft_rst, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [33:0] qr[$], e;
   logic [1:0] qb[$];
   integer seed = 21024, err_total = 0, checks = 0, cyc = 0;
   always #2.5 aclk = ~aclk;
   gcr_chip_regs #(.REVISION_CODE(4'h3), .PART_CODE(16'h1234), .MAKER_CODE(11'h155))
      u_gcr_chip_regs (.*);
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      checks++;
      if (s !== x) begin
         err_total++;
         $display("CHECK FAILED %s exp %h seen %h", n, x, s);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // write: both channels offered, each released when taken
   task automatic wr(input logic [8:0] a, input logic [31:0] v, input logic [1:0] r);
      qb.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!(s_axi_bvalid && s_axi_bready));
   endtask
   task automatic rd(input logic [8:0] a, input logic [31:0] x, input logic [1:0] r);
      qr.push_back({r, x});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!(s_axi_rvalid && s_axi_rready));
   endtask
   task automatic irqc(input logic x);
      repeat (3) @(posedge aclk);
      chk("irq", {31'h0, irq}, {31'h0, x});
   endtask
   // answer monitor against queued notes, core reset watch, timeout
   always @(posedge aclk) begin
      cyc++;
      if (s_axi_rvalid && s_axi_rready) begin
         e = qr.pop_front();
         chk("rdata", s_axi_rdata, e[31:0]);
         chk("rresp", {30'h0, s_axi_rresp}, {30'h0, e[33:32]});
      end
      if (s_axi_bvalid && s_axi_bready) chk("bresp", {30'h0, s_axi_bresp}, {30'h0, qb.pop_front()});
      if (proc_soft_rst) pcnt <= pcnt + 32'h1;
      if (chip_soft_rst) ccnt <= ccnt + 32'h1;
      if (cyc == 5000) begin
         err_total++;
         end_sim();
      end
   end
   // main sequence
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(OFS_CHIP_IDENTIFICATION, ID, RESP_OKAY);
      rd(OFS_SCRATCH, 0, RESP_OKAY);
      rd(OFS_RST_CTRL, 0, RESP_OKAY);
      rd(OFS_HARDWARE_STATUS, 0, RESP_OKAY);
      repeat (4) begin
         d = $random(seed);
         wr(OFS_SCRATCH, d, RESP_OKAY);
         rd(OFS_SCRATCH, d, RESP_OKAY);
      end
      wr(OFS_CHIP_IDENTIFICATION, ~ID, RESP_OKAY);
      wr(OFS_HARDWARE_STATUS, 32'h1, RESP_OKAY);
      rd(OFS_CHIP_IDENTIFICATION, ID, RESP_OKAY);
      rd(OFS_HARDWARE_STATUS, 0, RESP_OKAY);
      wr(OFS_PROC_ACCESS_GRP, 32'h1, RESP_SLVERR);
      rd(OFS_MDIO_SCAN_GRP, 0, RESP_SLVERR);
      wr(OFS_RST_CTRL, 32'h1, RESP_OKAY);
      repeat (12) @(posedge aclk);
      chk("core_rst", pcnt, {28'h0, SOFT_RST_CYCLES});
      chk("chip_rst", ccnt, {28'h0, SOFT_RST_CYCLES});
      rd(OFS_RST_CTRL, 0, RESP_OKAY);
      rd(OFS_SCRATCH, 0, RESP_OKAY);
      rd(OFS_IRQ_STAT, 32'h2, RESP_OKAY);
      wr(OFS_IRQ_MASK, 32'h2, RESP_OKAY);
      irqc(1'b1);
      wr(OFS_IRQ_STAT, 32'h2, RESP_OKAY);
      irqc(1'b0);
      proc_rst_protect <= 1'b1;
      repeat (6) @(posedge aclk);
      wr(OFS_RST_CTRL, 32'h1, RESP_OKAY);
      repeat (12) @(posedge aclk);
      chk("core_rst", pcnt, {28'h0, SOFT_RST_CYCLES});
      chk("chip_rst", ccnt, {27'h0, SOFT_RST_CYCLES, 1'b0});
      irqc(1'b1);
      wr(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
      irqc(1'b0);
      mem_init_fail <= 1'b1;
      repeat (5) @(posedge aclk);
      rd(OFS_HARDWARE_STATUS, 32'h1, RESP_OKAY);
      end_sim();
   end
endmodule
